// ===== verification/ddrsp_host.sv
module ddrsp_host
  import ddrsp_pkg::*;
(
  // Clock
  input  wire logic        i_core_clk,
  // Pins toward the port
  output logic             o_k,
  output logic             o_k_n,
  output logic             o_c,
  output logic             o_c_n,
  output logic             o_load_strobe_n,
  output logic             o_dir_read,
  output logic [19:0]      o_addr,
  output logic [3:0]       o_mask_n,
  output logic [35:0]      o_dq,
  // Read side
  input  wire logic [35:0] i_dq,
  input  wire logic        i_dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        single = 1'b0;
  logic [35:0] q_rise;
  logic [35:0] q_fall;
  logic        oe_rise;
  logic        oe_fall;
  task automatic w(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic strobe(input logic v);
    o_k   = v;
    o_k_n = ~v;
    o_c   = single | v;
    o_c_n = single | ~v;
  endtask
  // One strobe period of 160 ns; values are held well past each edge for the sampler.
  task automatic step(input logic load_n, rd, wr, input logic [19:0] a,
                      input logic [35:0] d0, d1, input logic [3:0] m0, m1);
    o_load_strobe_n = load_n;
    o_dir_read      = rd;
    o_addr          = a;
    o_dq            = wr ? d0 : ~o_dq;
    o_mask_n        = m0;
    w(3);
    strobe(1'b1);
    w(5);
    q_rise  = i_dq;
    oe_rise = i_dq_oe;
    o_dq     = wr ? d1 : ~o_dq;
    o_mask_n = m1;
    w(3);
    strobe(1'b0);
    w(5);
    q_fall  = i_dq;
    oe_fall = i_dq_oe;
  endtask
  task automatic stop(input int n);
    repeat (n)
    begin
      o_load_strobe_n = ~o_load_strobe_n;
      o_dir_read      = ~o_dir_read;
      w(1);
    end
  endtask
  initial
  begin
    strobe(1'b0);
    o_load_strobe_n = 1'b1;
    o_dir_read      = 1'b0;
    o_addr          = 20'h0;
    o_mask_n        = 4'hf;
    o_dq            = 36'h0;
  end
endmodule

// ===== verification/ddrsp_port_props.sv
module ddrsp_port_props
  import ddrsp_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int LANES  = 4
)
(
  // Clock and reset
  input wire logic                    i_core_clk,
  input wire logic                    i_rst,
  // Inputs
  input wire logic                    i_k,
  input wire logic                    i_k_n,
  input wire logic                    i_c,
  input wire logic                    i_c_n,
  input wire logic                    i_load_strobe_n,
  input wire logic                    i_dir_read,
  input wire logic [ADDR_W-1:0]       i_addr,
  input wire logic [LANES-1:0]        i_lane_write_mask_n,
  input wire logic [LANES*LANE_W-1:0] i_dq,
  // Outputs
  input wire logic [LANES*LANE_W-1:0] o_dq,
  input wire logic                    o_dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // Helpers
  logic       k_d;
  logic [1:0] idle_d;
  logic [5:0] since_rd;
  logic [3:0] since_edge;
  logic [3:0] strb_d;
  wire        k_rise = i_k & ~k_d;
  wire  [3:0] strb   = {i_k, i_k_n, i_c, i_c_n};
  // Both counters saturate, so a long stop never wraps into a false pass.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      k_d        <= 1'b0;
      idle_d     <= 2'b11;
      since_rd   <= 6'h3f;
      since_edge <= 4'hf;
      strb_d     <= 4'h0;
    end
    else
    begin
      k_d        <= i_k;
      strb_d     <= strb;
      idle_d     <= k_rise ? {idle_d[0], i_load_strobe_n} : idle_d;
      since_rd   <= (k_rise && !i_load_strobe_n && i_dir_read) ? 6'h0 : since_rd + 6'(since_rd != 6'h3f);
      since_edge <= (strb != strb_d) ? 4'h0 : since_edge + 4'(since_edge != 4'hf);
    end
  end
  // ========
  // Properties
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence read_cmd;
    k_rise && !i_load_strobe_n && i_dir_read;
  endsequence
  // A read two edges back still drives beat two, so only a third idle edge must release.
  sequence three_idles;
    k_rise && i_load_strobe_n && idle_d == 2'b11;
  endsequence
  a_reset_quiet: assert property ($fell(i_rst) |-> !o_dq_oe && o_dq == '0)
    else $error("bus driven right after reset");
  a_read_drives: assert property (read_cmd |-> ##[1:32] o_dq_oe)
    else $error("read did not drive the bus");
  a_oe_needs_read: assert property ($rose(o_dq_oe) |-> since_rd < 6'd32)
    else $error("bus driven without a read");
  a_oe_holds_beats: assert property ($rose(o_dq_oe) |=> o_dq_oe [*8])
    else $error("enable dropped inside a burst");
  a_idle_release: assert property (three_idles |-> ##[1:8] !o_dq_oe)
    else $error("bus not released on idle");
  a_stop_holds: assert property ($stable(strb) [*8] |=> $stable(o_dq) && $stable(o_dq_oe))
    else $error("outputs moved with strobes stopped");
  a_dq_edge_timed: assert property ($changed(o_dq) |-> since_edge < 4'd6)
    else $error("data changed away from a strobe edge");
  a_oe_edge_timed: assert property ($changed(o_dq_oe) |-> since_edge < 4'd6)
    else $error("enable changed away from a strobe edge");
endmodule

bind ddrsp_port ddrsp_port_props #(.ADDR_W(ADDR_W), .LANES(LANES)) u_props (.i_core_clk, .i_rst, .i_k,
  .i_k_n, .i_c, .i_c_n, .i_load_strobe_n, .i_dir_read, .i_addr, .i_lane_write_mask_n, .i_dq, .o_dq, .o_dq_oe);

// ===== verification/test_ddr_burst_two_cio_sram_port.sv
module test_ddr_burst_two_cio_sram_port;
  timeunit 1ns;
  timeprecision 1ps;
  import ddrsp_pkg::*;
  logic        clk, rst, k, k_n, c, c_n, load_n, rd, oe, save_oe;
  logic [19:0] addr;
  logic [3:0]  mask_n;
  logic [35:0] dq_in, dq_out, save;
  logic [35:0] mem [64];
  int          fails = 0;
  int          comparisons = 0;
  int          cycles = 0;
  ddrsp_port dut (.i_core_clk(clk), .i_rst(rst), .i_k(k), .i_k_n(k_n), .i_c(c), .i_c_n(c_n),
    .i_load_strobe_n(load_n), .i_dir_read(rd), .i_addr(addr), .i_lane_write_mask_n(mask_n),
    .i_dq(dq_in), .o_dq(dq_out), .o_dq_oe(oe));
  ddrsp_host host (.i_core_clk(clk), .o_k(k), .o_k_n(k_n), .o_c(c), .o_c_n(c_n), .o_load_strobe_n(load_n),
    .o_dir_read(rd), .o_addr(addr), .o_mask_n(mask_n), .o_dq(dq_in), .i_dq(dq_out), .i_dq_oe(oe));
  // ========
  // Shared tasks
  task automatic check(input string what, input logic [35:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [35:0] merge(input logic [35:0] old, d, input logic [3:0] m);
    for (int i = 0; i < 4; i++)
      if (!m[i])
        old[i*9 +: 9] = d[i*9 +: 9];
    return old;
  endfunction
  task automatic idle_cycle();
    host.step(1'b1, 1'b1, 1'b0, '1, '0, '0, '1, '1);
  endtask
  task automatic write(input logic [5:0] a, input logic [35:0] d0, d1, input logic [3:0] m0, m1);
    idle_cycle();
    host.step(1'b0, 1'b0, 1'b0, {14'h0, a}, '0, '0, '1, '1);
    host.step(1'b1, 1'b0, 1'b1, '0, d0, d1, m0, m1);
    mem[a] = merge(mem[a], d0, m0);
    mem[a^6'h1] = merge(mem[a^6'h1], d1, m1);
  endtask
  // Beat one stands from one and a half strobe periods after the command, beat two from two.
  task automatic read(input logic [5:0] a);
    host.step(1'b0, 1'b1, 1'b0, {14'h0, a}, '0, '0, '1, '1);
    idle_cycle();
    check("beat one", mem[a], host.q_fall);
    check("enable", 36'h1, {35'h0, host.oe_fall});
    idle_cycle();
    check("beat two", mem[a^6'h1], host.q_rise);
    check("enable", 36'h1, {35'h0, host.oe_rise});
  endtask
  // ========
  // Scenarios
  task automatic t_basic();
    write(6'h05, 36'h9_1234_5678, 36'h6_edcb_a987, 4'h0, 4'h0);
    read(6'h05);
    read(6'h04);
  endtask
  task automatic t_lanes();
    write(6'h08, 36'h0, 36'hf_ffff_ffff, 4'h0, 4'h0);
    for (int i = 0; i < 5; i++)
    begin
      write(6'h08, {4{9'(i*37+1)}}, {4{9'(i*91+2)}}, 4'(~(1 << i)), 4'(~(8 >> i)));
      read(6'h08);
    end
  endtask
  task automatic t_idle();
    idle_cycle();
    idle_cycle();
    check("idle enable", 36'h0, {35'h0, host.oe_rise});
    check("idle enable", 36'h0, {35'h0, host.oe_fall});
    read(6'h05);
  endtask
  task automatic t_stop();
    read(6'h04);
    save = dq_out;
    save_oe = oe;
    host.stop(40);
    check("held data", save, dq_out);
    check("held enable", {35'h0, save_oe}, {35'h0, oe});
    idle_cycle();
  endtask
  task automatic t_single();
    host.single = 1'b1;
    idle_cycle();
    read(6'h05);
    read(6'h08);
  endtask
  // ========
  // Run control
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      give_verdict();
    end
  end
  initial
  begin
    rst = 1'b1;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    t_basic();
    t_lanes();
    t_idle();
    t_stop();
    t_single();
    give_verdict();
  end
endmodule

// ===== verilog/ddrsp_pkg.sv
package ddrsp_pkg;

  // ==========================================================================
  // Organisation and lane layout
  // ==========================================================================
  localparam int LANE_W      = 9;
  localparam int LANES_X36   = 4;
  localparam int ADDR_W_DEF  = 20;
  localparam int DEPTH_W_DEF = 6;

  // ==========================================================================
  // Link timing: core clock period in ns and synchroniser depth in stages
  // ==========================================================================
  localparam int CORE_PERIOD_NS = 10;
  localparam int SYNC_STAGES    = 2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    DDRSP_IDLE  = 2'b00,
    DDRSP_READ  = 2'b01,
    DDRSP_WRITE = 2'b11
  } ddrsp_cmd_e;

  // Sampled strobe levels after synchronisation.
  typedef struct packed {
    logic k;
    logic k_n;
    logic c;
    logic c_n;
  } ddrsp_strobes_s;

  // Linear wrap of the burst start bit within the pair.
  function automatic logic ddrsp_second_lsb(input logic start_lsb);
    ddrsp_second_lsb = ~start_lsb;
  endfunction

endpackage

// ===== verilog/ddrsp_port.sv
// Contract
// - Second beat address flips the start lsb, wrapping within the pair.
// - Read: direction high, load low at primary strobe rise; two-beat read.
// - Write: direction low, load low at primary strobe rise; two beats later.
// - New start address captured only when load strobe is low.
// - Load high is an idle cycle; bus is released at a primary strobe rise with load high and no read beat pending.
// - Narrow organisation: lane masks gate bits 0-8 and 9-17 per beat.
// - Wide organisation: four 9-bit lanes, each gated per beat.
// - All masks low writes full word; all high aborts the beat.
// - With strobes stopped, data pins keep their previous state.
// - Output strobes both tied high: time reads from input strobes.
// - Reads of the two latest written addresses return data straight from the array.
module ddrsp_port
  import ddrsp_pkg::*;
#(
  parameter int ADDR_W  = ADDR_W_DEF,
  parameter int LANES   = LANES_X36,
  parameter int DEPTH_W = DEPTH_W_DEF
)
(
  // Clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst,
  // Strobes from the host
  input  wire logic                      i_k,
  input  wire logic                      i_k_n,
  input  wire logic                      i_c,
  input  wire logic                      i_c_n,
  // Commands
  input  wire logic                      i_load_strobe_n,
  input  wire logic                      i_dir_read,
  input  wire logic [ADDR_W-1:0]         i_addr,
  input  wire logic [LANES-1:0]          i_lane_write_mask_n,
  // Common data bus
  input  wire logic [LANES*LANE_W-1:0]   i_dq,
  output logic      [LANES*LANE_W-1:0]   o_dq,
  output logic                           o_dq_oe
);

  localparam int DW    = LANES * LANE_W;
  localparam int DEPTH = 1 << DEPTH_W;

  // Elaboration refuses organisations other than two or four lanes.
  if (!(LANES == 2 || LANES == 4) || ADDR_W < 1 || DEPTH_W < 1 || DEPTH_W > ADDR_W)
  begin : g_bad_params
    $error("ddrsp_port: unsupported parameters");
  end

  // ==========================================================================
  // Strobe sampling and edge detection
  // ==========================================================================
  ddrsp_strobes_s sync_raw;
  ddrsp_strobes_s sync_q;
  logic [ADDR_W+LANES+DW+1:0] in_raw;
  logic [ADDR_W+LANES+DW+1:0] in_q;

  ddrsp_sync #(.WIDTH(4)) u_sync_strobe (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    ({i_k, i_k_n, i_c, i_c_n}),
    .o_sync     (sync_raw)
  );

  ddrsp_sync #(.WIDTH(ADDR_W+LANES+DW+2)) u_sync_in (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    ({i_load_strobe_n, i_dir_read, i_addr, i_lane_write_mask_n, i_dq}),
    .o_sync     (in_raw)
  );

  // Inputs are delayed one more stage so the data line up with the strobe
  // edge seen here; the host must hold them across the strobe edge.
  ddrsp_strobes_s prev_q;
  logic k_rise;
  logic kn_rise;
  logic c_rise;
  logic cn_rise;
  logic load_n;
  logic rd;
  logic [ADDR_W-1:0] a_in;
  logic [LANES-1:0]  m_in;
  logic [DW-1:0]     d_in;
  logic              single_clk;

  assign {load_n, rd, a_in, m_in, d_in} = in_q;
  assign k_rise  = sync_q.k & ~prev_q.k;
  assign kn_rise = sync_q.k_n & ~prev_q.k_n;
  assign c_rise  = sync_q.c & ~prev_q.c;
  assign cn_rise = sync_q.c_n & ~prev_q.c_n;
  assign single_clk = sync_q.c & sync_q.c_n & prev_q.c & prev_q.c_n;

  // ==========================================================================
  // Command, write and read state
  // ==========================================================================
  logic [DW-1:0]     mem [DEPTH];
  typedef enum logic [1:0] {
    WR_IDLE  = 2'b00,
    WR_BEAT1 = 2'b01,
    WR_BEAT2 = 2'b11
  } ddrsp_wr_e;

  // A read waits one complement rise before beat one: output C#, or input K# when C and C# are both high.
  typedef enum logic [1:0] {
    RD_IDLE  = 2'b00,
    RD_WAIT  = 2'b01,
    RD_ARMED = 2'b11,
    RD_BEAT2 = 2'b10
  } ddrsp_rd_e;

  ddrsp_wr_e         wr_pend;
  ddrsp_wr_e         next_wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [ADDR_W-1:0] wr_addr2;
  logic [ADDR_W-1:0] rd_addr2;
  ddrsp_rd_e         rd_pend;
  ddrsp_rd_e         next_rd_pend;
  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W-1:0] next_rd_addr;
  logic [DW-1:0]     next_dq;
  logic              next_oe;
  logic              wr_en;
  logic [DEPTH_W-1:0] wr_idx;
  logic [DW-1:0]     wr_word;
  logic              rd_beat1;
  logic              rd_beat2;

  // Lane-masked merge; a beat whose masks are all high leaves the word.
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
                                          input logic [DW-1:0] new_w,
                                          input logic [LANES-1:0] mask_n);
    logic [DW-1:0] r;
    r = old_w;
    for (int l = 0; l < LANES; l++)
      if (!mask_n[l])
        r[l*LANE_W +: LANE_W] = new_w[l*LANE_W +: LANE_W];
    merge = r;
  endfunction

  function automatic logic [ADDR_W-1:0] beat2(input logic [ADDR_W-1:0] a);
    beat2 = {a[ADDR_W-1:1], ddrsp_second_lsb(a[0])};
  endfunction

  always_comb
  begin
    next_wr_pend    = wr_pend;
    next_wr_addr    = wr_addr;
    next_rd_pend    = rd_pend;
    next_rd_addr    = rd_addr;
    next_dq         = o_dq;
    next_oe         = o_dq_oe;
    wr_en           = 1'b0;
    wr_idx          = '0;
    wr_word         = '0;
    wr_addr2        = beat2(wr_addr);
    rd_addr2        = beat2(rd_addr);
    rd_beat1 = single_clk ? kn_rise : cn_rise;
    rd_beat2 = single_clk ? k_rise : c_rise;
    // Write beats; strobes that stop simply leave everything as is.
    if (k_rise && wr_pend == WR_BEAT1)
    begin
      wr_en        = 1'b1;
      wr_idx       = wr_addr[DEPTH_W-1:0];
      wr_word      = merge(mem[wr_idx], d_in, m_in);
      next_wr_pend = WR_BEAT2;
      next_oe      = 1'b0;
    end
    else if (kn_rise && wr_pend == WR_BEAT2)
    begin
      wr_en        = 1'b1;
      wr_idx       = wr_addr2[DEPTH_W-1:0];
      wr_word      = merge(mem[wr_idx], d_in, m_in);
      next_wr_pend = WR_IDLE;
    end
    // An idle cycle does not cut a read short: the bus is released only with no beat left.
    if (k_rise && load_n && rd_pend == RD_IDLE)
      next_oe = 1'b0;
    // Read beats come from the array, already holding the latest writes.
    if (rd_beat1 && rd_pend == RD_WAIT)
      next_rd_pend = RD_ARMED;
    else if (rd_beat1 && rd_pend == RD_ARMED)
    begin
      next_dq      = mem[rd_addr[DEPTH_W-1:0]];
      next_oe      = 1'b1;
      next_rd_pend = RD_BEAT2;
    end
    else if (rd_beat2 && rd_pend == RD_BEAT2)
    begin
      next_dq      = mem[rd_addr2[DEPTH_W-1:0]];
      next_oe      = 1'b1;
      next_rd_pend = RD_IDLE;
    end
    // Command edge; the edge that takes write beat one carries no command.
    if (k_rise && !load_n && wr_pend != WR_BEAT1)
    begin
      if (rd)
      begin
        next_rd_pend = RD_WAIT;
        next_rd_addr = a_in;
      end
      else
      begin
        next_wr_pend = WR_BEAT1;
        next_wr_addr = a_in;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync_q     <= '0;
      prev_q     <= '0;
      in_q       <= '0;
      wr_pend    <= WR_IDLE;
      wr_addr    <= '0;
      rd_pend    <= RD_IDLE;
      rd_addr    <= '0;
      o_dq       <= '0;
      o_dq_oe    <= 1'b0;
    end
    else
    begin
      sync_q     <= sync_raw;
      prev_q     <= sync_q;
      in_q       <= in_raw;
      wr_pend    <= next_wr_pend;
      wr_addr    <= next_wr_addr;
      rd_pend    <= next_rd_pend;
      rd_addr    <= next_rd_addr;
      o_dq       <= next_dq;
      o_dq_oe    <= next_oe;
    end
  end

  // The array has no reset: contents are undefined until written.
  always_ff @(posedge i_core_clk)
  begin
    if (wr_en)
      mem[wr_idx] <= wr_word;
  end

endmodule

// ===== verilog/ddrsp_sync.sv
module ddrsp_sync
  import ddrsp_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  // Data
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  always_comb
  begin
    next_meta = i_async;
    next_sync = meta;
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta   <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta   <= next_meta;
      o_sync <= next_sync;
    end
  end

endmodule
